// ### cch_defines.svh
// constants for the caption decoder host register block
`ifndef CCH_DEFINES_SVH
`define CCH_DEFINES_SVH

// bus target address, value is arbitrary
`define CCH_I2C_ADDR        7'h2A

`define CCH_REG_CTRL0       8'h00
`define CCH_REG_CTRL1       8'h01
`define CCH_REG_ROW         8'h02
`define CCH_REG_COL         8'h03
`define CCH_REG_CHAR        8'h04
`define CCH_REG_STATUS      8'h80
`define CCH_REG_BYTE1       8'h81
`define CCH_REG_BYTE2       8'h82

`define CCH_WPTR_LAST       3'h4
`define CCH_RPTR_LAST       2'h2

`define CCH_BIT_READY       0
`define CCH_BIT_HALT        1
`define CCH_BIT_EXT_SVC     2
`define CCH_BIT_FIELD       3
`define CCH_BIT_POR         7
`define CCH_BIT_CHANNEL     6

`define CCH_RST_BYTE        8'h00
`define CCH_RST_POR         1'h1

`endif

// ### cch_pkg.sv
// types shared by the caption decoder host register block
package cch_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_RX    = 3'b011,
    ST_TX    = 3'b100,
    ST_TXACK = 3'b101
  } cch_bus_state_type;

  typedef enum logic [1:0] {
    DISP_VIDEO    = 2'b00,
    DISP_TEXT     = 2'b01,
    DISP_NORMAL   = 2'b10,
    DISP_ENHANCED = 2'b11
  } cch_disp_type;

  typedef enum logic [1:0] {
    STY_SHADOW_VIDEO = 2'b00,
    STY_SHADOW_MESH  = 2'b01,
    STY_NORMAL_VIDEO = 2'b10,
    STY_NORMAL_MESH  = 2'b11
  } cch_style_type;

endpackage : cch_pkg

// ### cch_host_regs.sv
// host-side register bank, bus target and pin-mode logic of the caption decoder
`include "cch_defines.svh"

module cch_host_regs
  import cch_pkg::*;
(
  input  wire logic       REF_CLK,            // block clock, 125 MHz
  input  wire logic       RST_B,              // synchronous reset, active low
  input  wire logic       ACQ_CLK,            // acquisition side clock
  input  wire logic       ACQ_RST_B,          // acquisition side reset, active low
  input  wire logic       HOST_PORT_SELECT,   // high: bus port, low: pin control
  input  wire logic       SCL_I,              // bus clock pin level
  input  wire logic       SDA_I,              // bus data pin level
  output logic            SDA_O,              // bus data drive value
  output logic            SDA_OE,             // bus data drive enable
  input  wire logic       ACQ_READY_PIN_N_I,  // ready pin level
  output logic            ACQ_READY_PIN_N_O,  // ready pin drive value
  output logic            ACQ_READY_PIN_N_OE, // ready pin drive enable
  input  wire logic       ACQ_VALID,          // new caption pair, one pulse
  input  wire logic [7:0] ACQ_BYTE_FIRST,     // first byte, parity error in bit 7
  input  wire logic [7:0] ACQ_BYTE_SECOND,    // second byte, parity error in bit 7
  input  wire logic       ACQ_EXT_SVC,        // pair is extended data service
  input  wire logic       ACQ_FIELD,          // pair came from field 2
  input  wire logic       ACQ_PARITY_HALT,    // parity shut-down level
  output logic [1:0]      DISPLAY_MODE,       // selected display mode
  output logic [1:0]      STYLE_MODE,         // selected character style
  output logic            BLACK_BACKGROUND,   // black box behind characters
  output logic            CHANNEL_SEL,        // high: caption channel 2
  output logic [7:0]      CTRL_BYTE0,         // register 0 contents
  output logic [7:0]      CTRL_BYTE1,         // register 1 contents
  output logic            OSD_WE,             // overlay character write pulse
  output logic [3:0]      OSD_ROW,            // overlay row of the write
  output logic [4:0]      OSD_COL,            // overlay column of the write
  output logic [6:0]      OSD_CODE            // overlay character code
);

  // acquisition domain: hold the pair and flag it by a toggle
  logic [7:0] acq_first;
  logic [7:0] acq_second;
  logic       acq_svc;
  logic       acq_field;
  logic       acq_tog;

  // words stay put until the next pulse, so the toggle alone need cross
  always_ff @(posedge ACQ_CLK) begin
    if (!ACQ_RST_B) begin
      acq_tog    <= 1'b0;
      acq_first  <= `CCH_RST_BYTE;
      acq_second <= `CCH_RST_BYTE;
      acq_svc    <= 1'b0;
      acq_field  <= 1'b0;
    end else if (ACQ_VALID) begin
      acq_tog    <= ~acq_tog;
      acq_first  <= ACQ_BYTE_FIRST;
      acq_second <= ACQ_BYTE_SECOND;
      acq_svc    <= ACQ_EXT_SVC;
      acq_field  <= ACQ_FIELD;
    end
  end

  // pin and crossing synchronisers
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic rdy_m, rdy_s;
  logic sel_m, sel_s;
  logic halt_m, halt_s;
  logic tog_m, tog_s, tog_d;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {rdy_m, rdy_s}        <= 2'h0;
      {sel_m, sel_s}        <= 2'h0;
      {halt_m, halt_s}      <= 2'h0;
      {tog_m, tog_s, tog_d} <= 3'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {SCL_I, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {SDA_I, sda_m, sda_s};
      {rdy_m, rdy_s}        <= {ACQ_READY_PIN_N_I, rdy_m};
      {sel_m, sel_s}        <= {HOST_PORT_SELECT, sel_m};
      {halt_m, halt_s}      <= {ACQ_PARITY_HALT, halt_m};
      {tog_m, tog_s, tog_d} <= {acq_tog, tog_m, tog_s};
    end
  end

  // bus state
  cch_bus_state_type state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic       rw, next_rw;
  logic       first, next_first;
  logic       sda_oe, next_sda_oe;
  logic [2:0] wptr;
  logic [1:0] rptr;

  // register bank
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [3:0] overlay_row_bits;
  logic [4:0] overlay_col_bits;
  logic [7:0] first_caption_byte;
  logic [7:0] second_caption_byte;
  logic       data_ready;
  logic       parity_halt_flag;
  logic       extended_service_flag;
  logic       field_indicator;
  logic       por_flag;

  wire i2c_on     = sel_s;
  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  wire fsm_live   = i2c_on & ~start_cond & ~stop_cond;
  wire byte_done  = scl_rise & (bit_cnt == 3'h7);
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  wire addr_hit   = (rx_byte[7:1] == `CCH_I2C_ADDR);

  wire wr_ev   = fsm_live & (state == ST_RX) & byte_done;
  wire sub_ev  = wr_ev & first;
  wire data_ev = wr_ev & ~first;
  wire rd_ev   = fsm_live & (state == ST_TX) & byte_done;
  wire acq_ev  = tog_s ^ tog_d;

  wire [7:0] status_byte = {por_flag, 3'h0, field_indicator, extended_service_flag,
                            parity_halt_flag, data_ready};
  wire [7:0] rd_byte = (rptr == 2'h0) ? status_byte :
                       (rptr == 2'h1) ? first_caption_byte : second_caption_byte;
  wire rd_status = rd_ev & (rptr == 2'h0);

  // bus target sequencing
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_rw      = rw;
    next_first   = first;
    next_sda_oe  = sda_oe;
    if (!i2c_on || stop_cond) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_cond) begin
      next_state   = ST_ADDR;
      next_bit_cnt = 3'h0;
      next_sda_oe  = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            next_shift   = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (byte_done) begin
            next_bit_cnt = 3'h0;
            next_state   = ST_ACK;
            if (state == ST_ADDR) begin
              next_rw    = rx_byte[0];
              next_first = 1'b1;
              if (!addr_hit) begin
                next_state = ST_IDLE;
              end
            end else begin
              next_first = 1'b0;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall && bit_cnt == 3'h0) begin
            next_sda_oe  = 1'b1;
            next_bit_cnt = 3'h1;
          end else if (scl_fall) begin
            next_bit_cnt = 3'h0;
            if (rw) begin
              next_state  = ST_TX;
              next_shift  = rd_byte;
              next_sda_oe = ~rd_byte[7];
            end else begin
              next_state  = ST_RX;
              next_sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            next_shift  = {shift[6:0], 1'b0};
            next_sda_oe = ~shift[6];
          end
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
          if (byte_done) begin
            next_bit_cnt = 3'h0;
            next_state   = ST_TXACK;
          end
        end
        ST_TXACK: begin
          // a not-acknowledge ends the read; the stop comes next
          if (scl_fall && bit_cnt == 3'h0) begin
            next_sda_oe = 1'b0;
          end else if (scl_rise) begin
            next_bit_cnt = 3'h1;
            if (sda_s) begin
              next_state = ST_IDLE;
            end
          end else if (scl_fall) begin
            next_bit_cnt = 3'h0;
            next_state   = ST_TX;
            next_shift   = rd_byte;
            next_sda_oe  = ~rd_byte[7];
          end
        end
        default: begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state   <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift   <= `CCH_RST_BYTE;
      rw      <= 1'b0;
      first   <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
      rw      <= next_rw;
      first   <= next_first;
      sda_oe  <= next_sda_oe;
    end
  end

  // subaddress pointers
  wire [2:0] sub_wptr  = (rx_byte[6:0] > 7'(`CCH_WPTR_LAST)) ? `CCH_WPTR_LAST : rx_byte[2:0];
  wire [1:0] sub_rptr  = (rx_byte[1:0] > `CCH_RPTR_LAST) ? `CCH_RPTR_LAST : rx_byte[1:0];
  wire [2:0] next_wptr = (sub_ev && !rx_byte[7]) ? sub_wptr :
                         (data_ev && wptr != `CCH_WPTR_LAST) ? wptr + 3'h1 : wptr;
  wire [1:0] next_rptr = (sub_ev && rx_byte[7]) ? sub_rptr :
                         (rd_ev && rptr != `CCH_RPTR_LAST) ? rptr + 2'h1 : rptr;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      wptr <= 3'h0;
      rptr <= 2'h0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // write bank decode
  wire wr_ctrl0 = data_ev & (wptr == 3'(`CCH_REG_CTRL0));
  wire wr_ctrl1 = data_ev & (wptr == 3'(`CCH_REG_CTRL1));
  wire wr_row   = data_ev & (wptr == 3'(`CCH_REG_ROW));
  wire wr_col   = data_ev & (wptr == 3'(`CCH_REG_COL));
  wire wr_char  = data_ev & (wptr == 3'(`CCH_REG_CHAR));
  wire col_wrap = wr_char & (overlay_col_bits == 5'h1F);
  wire [4:0] next_col = wr_col ? rx_byte[4:0] :
                        wr_char ? overlay_col_bits + 5'h1 : overlay_col_bits;
  wire [3:0] next_row = wr_row ? rx_byte[3:0] :
                        col_wrap ? overlay_row_bits + 4'h1 : overlay_row_bits;

  // power-on clears the whole write bank
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      ctrl0            <= `CCH_RST_BYTE;
      ctrl1            <= `CCH_RST_BYTE;
      overlay_row_bits <= 4'h0;
      overlay_col_bits <= 5'h00;
      OSD_WE           <= 1'b0;
      OSD_ROW          <= 4'h0;
      OSD_COL          <= 5'h00;
      OSD_CODE         <= 7'h00;
    end else begin
      ctrl0            <= wr_ctrl0 ? rx_byte : ctrl0;
      ctrl1            <= wr_ctrl1 ? rx_byte : ctrl1;
      overlay_row_bits <= next_row;
      overlay_col_bits <= next_col;
      OSD_WE           <= wr_char;
      OSD_ROW          <= wr_char ? overlay_row_bits : OSD_ROW;
      OSD_COL          <= wr_char ? overlay_col_bits : OSD_COL;
      OSD_CODE         <= wr_char ? rx_byte[6:0] : OSD_CODE;
    end
  end

  // status: a new pair or a live shut-down outranks the read clear
  wire next_ready = acq_ev ? 1'b1 : (rd_ev ? 1'b0 : data_ready);
  wire next_halt  = halt_s ? 1'b1 : (rd_status ? 1'b0 : parity_halt_flag);
  wire next_svc   = acq_ev ? acq_svc : (rd_status ? 1'b0 : extended_service_flag);
  wire next_field = acq_ev ? acq_field : (rd_status ? 1'b0 : field_indicator);
  wire next_por   = rd_status ? 1'b0 : por_flag;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      data_ready            <= 1'b0;
      parity_halt_flag      <= 1'b0;
      extended_service_flag <= 1'b0;
      field_indicator       <= 1'b0;
      por_flag              <= `CCH_RST_POR;
      first_caption_byte    <= `CCH_RST_BYTE;
      second_caption_byte   <= `CCH_RST_BYTE;
    end else begin
      data_ready            <= next_ready;
      parity_halt_flag      <= next_halt;
      extended_service_flag <= next_svc;
      field_indicator       <= next_field;
      por_flag              <= next_por;
      first_caption_byte    <= acq_ev ? acq_first : first_caption_byte;
      second_caption_byte   <= acq_ev ? acq_second : second_caption_byte;
    end
  end

  // mode selection: register in bus mode, pins otherwise; black box only from the pins
  wire [1:0] pin_mode   = {scl_s, sda_s};
  wire       pin_normal = (pin_mode == DISP_NORMAL);
  wire [1:0] pin_style  = pin_normal ? STY_NORMAL_VIDEO : STY_SHADOW_VIDEO;
  wire [1:0] next_disp  = i2c_on ? ctrl1[1:0] : pin_mode;
  wire [1:0] next_style = i2c_on ? ctrl1[3:2] : pin_style;
  wire       next_black = ~i2c_on & pin_normal;
  wire       next_chan  = i2c_on ? ctrl1[`CCH_BIT_CHANNEL] : rdy_s;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      DISPLAY_MODE       <= DISP_VIDEO;
      STYLE_MODE         <= STY_SHADOW_VIDEO;
      BLACK_BACKGROUND   <= 1'b0;
      CHANNEL_SEL        <= 1'b0;
      CTRL_BYTE0         <= `CCH_RST_BYTE;
      CTRL_BYTE1         <= `CCH_RST_BYTE;
      SDA_O              <= 1'b0;
      SDA_OE             <= 1'b0;
      ACQ_READY_PIN_N_O  <= 1'b0;
      ACQ_READY_PIN_N_OE <= 1'b0;
    end else begin
      DISPLAY_MODE       <= next_disp;
      STYLE_MODE         <= next_style;
      BLACK_BACKGROUND   <= next_black;
      CHANNEL_SEL        <= next_chan;
      CTRL_BYTE0         <= ctrl0;
      CTRL_BYTE1         <= ctrl1;
      SDA_O              <= 1'b0;
      SDA_OE             <= sda_oe & i2c_on;
      ACQ_READY_PIN_N_O  <= 1'b0;
      ACQ_READY_PIN_N_OE <= data_ready & i2c_on;
    end
  end

endmodule : cch_host_regs

// ### cch_host_regs_properties.sv
// concurrent checks on the caption decoder host register ports
module cch_host_regs_properties (
  input wire logic       REF_CLK,            // block clock
  input wire logic       RST_B,              // block reset
  input wire logic       ACQ_CLK,            // link clock
  input wire logic       ACQ_RST_B,          // link reset
  input wire logic       HOST_PORT_SELECT,   // port mode
  input wire logic       SCL_I,              // clock pin
  input wire logic       SDA_I,              // data pin
  input wire logic       SDA_O,              // data drive
  input wire logic       SDA_OE,             // data enable
  input wire logic       ACQ_READY_PIN_N_I,  // ready pin
  input wire logic       ACQ_READY_PIN_N_O,  // ready drive
  input wire logic       ACQ_READY_PIN_N_OE, // ready enable
  input wire logic       ACQ_VALID,          // new pair
  input wire logic [1:0] DISPLAY_MODE,       // mode out
  input wire logic [1:0] STYLE_MODE,         // style out
  input wire logic       BLACK_BACKGROUND,   // black box
  input wire logic       CHANNEL_SEL,        // channel out
  input wire logic [7:0] CTRL_BYTE0,         // reg 0
  input wire logic [7:0] CTRL_BYTE1,         // reg 1
  input wire logic       OSD_WE,             // char write
  input wire logic [3:0] OSD_ROW,            // char row
  input wire logic [4:0] OSD_COL,            // char column
  input wire logic [6:0] OSD_CODE            // char code
);
  logic [3:0] since_acq;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  // saturating age of the last link pulse, so ready can be tied to a cause
  always_ff @(posedge REF_CLK) begin
    if (!RST_B)
      since_acq <= 4'hf;
    else if (ACQ_VALID)
      since_acq <= 4'h0;
    else if (since_acq != 4'hf)
      since_acq <= since_acq + 4'h1;
  end

  // five calm samples cover the pin synchronisers plus the output register
  sequence pin_settled;
    (!HOST_PORT_SELECT && $stable({SCL_I, SDA_I, ACQ_READY_PIN_N_I})) [*5];
  endsequence
  sequence bus_settled;
    HOST_PORT_SELECT [*5];
  endsequence

  chk_pin_display: assert property (pin_settled |-> DISPLAY_MODE == {SCL_I, SDA_I})
    else $error("pin display mode wrong");
  chk_pin_channel: assert property (pin_settled |-> CHANNEL_SEL == ACQ_READY_PIN_N_I)
    else $error("pin channel wrong");
  chk_pin_style: assert property (pin_settled |->
    STYLE_MODE == (({SCL_I, SDA_I} == 2'b10) ? 2'b10 : 2'b00) && BLACK_BACKGROUND == ({SCL_I, SDA_I} == 2'b10))
    else $error("pin style wrong");
  chk_pin_quiet: assert property (pin_settled |-> !SDA_OE && !ACQ_READY_PIN_N_OE)
    else $error("pin mode drives a bus pin");
  chk_bus_noblack: assert property (bus_settled |-> !BLACK_BACKGROUND)
    else $error("black box in bus mode");
  chk_ready_raise: assert property ($rose(ACQ_VALID) && HOST_PORT_SELECT |-> ##[1:8] ACQ_READY_PIN_N_OE)
    else $error("ready pin not driven after new pair");
  chk_ready_cause: assert property ($rose(ACQ_READY_PIN_N_OE) |-> since_acq <= 4'h8)
    else $error("ready pin without new pair");
  chk_open_drain: assert property (SDA_O == 1'b0 && ACQ_READY_PIN_N_O == 1'b0)
    else $error("open drain pin driven high");
  chk_osd_pulse: assert property (OSD_WE |=> !OSD_WE)
    else $error("char write pulse too long");
  chk_osd_hold: assert property (!$stable({OSD_ROW, OSD_COL, OSD_CODE}) |-> OSD_WE)
    else $error("char address changed without write");
  chk_reset_clear: assert property (disable iff (1'b0) !RST_B [*3] |->
    DISPLAY_MODE == 2'b00 && STYLE_MODE == 2'b00 && CTRL_BYTE0 == 8'h00 && CTRL_BYTE1 == 8'h00 && !OSD_WE)
    else $error("outputs not cleared by reset");
endmodule : cch_host_regs_properties

bind cch_host_regs cch_host_regs_properties u_props (
  .REF_CLK, .RST_B, .ACQ_CLK, .ACQ_RST_B, .HOST_PORT_SELECT, .SCL_I, .SDA_I, .SDA_O, .SDA_OE,
  .ACQ_READY_PIN_N_I, .ACQ_READY_PIN_N_O, .ACQ_READY_PIN_N_OE, .ACQ_VALID, .DISPLAY_MODE,
  .STYLE_MODE, .BLACK_BACKGROUND, .CHANNEL_SEL, .CTRL_BYTE0, .CTRL_BYTE1, .OSD_WE, .OSD_ROW,
  .OSD_COL, .OSD_CODE
);

// ### cch_host_model.sv
// bus controller model: drives the bus clock, pulls data low, reports read bytes
module cch_host_model (
  input  wire logic       clk,     // bench clock
  input  wire logic       sda,     // resolved data line
  output logic            scl,     // bus clock
  output logic            sda_oe,  // high pulls data low
  output logic            nack,    // last written byte refused
  output logic            rd_seen, // pulse per byte read
  output logic [7:0]      rd_byte  // byte just read
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QTR = 6;
  logic r;

  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    nack = 1'b0;
    rd_seen = 1'b0;
    rd_byte = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // data moves one clock after the fall so the target sees clock first
  task automatic bitx(input logic b);
    tick(1);
    sda_oe <= !b;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    r = sda;
    tick(QTR);
    scl <= 1'b0;
  endtask : bitx

  task automatic start();
    tick(1);
    sda_oe <= 1'b0;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_oe <= 1'b1;
    tick(QTR);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    tick(1);
    sda_oe <= 1'b1;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_oe <= 1'b0;
    tick(QTR);
  endtask : stop

  task automatic wbyte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitx(d[i]);
    bitx(1'b1);
    // blocking so the caller sees this byte's answer at once
    nack = r;
  endtask : wbyte

  task automatic rbyte(input logic last);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1);
      d[i] = r;
    end
    rd_byte <= d;
    rd_seen <= 1'b1;
    tick(1);
    rd_seen <= 1'b0;
    bitx(last);
  endtask : rbyte
endmodule : cch_host_model

// ### tb_top.sv
// self-checking bench for the caption decoder host register block
`include "cch_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0, acq_clk = 1'b0, rst_b = 1'b0, acq_rst_b = 1'b0, sel = 1'b1;
  logic        pin_scl = 1'b0, pin_sda = 1'b0, pin_rdy = 1'b0, acq_valid = 1'b0;
  logic        ext_svc = 1'b0, fld = 1'b0, halt = 1'b0;
  logic [7:0]  b1 = 8'h00, b2 = 8'h00, c0, c1, rd_byte, x, y;
  logic        sda_o, sda_oe, rdy_o, rdy_oe, black, chan, osd_we, h_scl, h_oe, h_nack, rd_seen;
  logic [1:0]  disp, sty, v;
  logic [3:0]  row;
  logic [4:0]  col;
  logic [6:0]  code;
  logic [31:0] seed = 32'h4bbd_f9f5, t;
  logic [7:0]  exp_rd[$];
  logic [15:0] exp_osd[$];
  int          err_total = 0, compares = 0, cyc = 0;

  // released lines float high through the pull-ups
  wire sda_w = !(sda_oe | h_oe);
  wire scl_w = sel ? h_scl : pin_scl;
  wire sda_i = sel ? sda_w : pin_sda;
  wire rdy_w = sel ? !rdy_oe : pin_rdy;

  always #4 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #16 acq_clk = ~acq_clk;
  end

  cch_host_regs dut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .ACQ_CLK(acq_clk), .ACQ_RST_B(acq_rst_b),
    .HOST_PORT_SELECT(sel), .SCL_I(scl_w), .SDA_I(sda_i), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .ACQ_READY_PIN_N_I(rdy_w), .ACQ_READY_PIN_N_O(rdy_o), .ACQ_READY_PIN_N_OE(rdy_oe),
    .ACQ_VALID(acq_valid), .ACQ_BYTE_FIRST(b1), .ACQ_BYTE_SECOND(b2), .ACQ_EXT_SVC(ext_svc),
    .ACQ_FIELD(fld), .ACQ_PARITY_HALT(halt), .DISPLAY_MODE(disp), .STYLE_MODE(sty),
    .BLACK_BACKGROUND(black), .CHANNEL_SEL(chan), .CTRL_BYTE0(c0), .CTRL_BYTE1(c1),
    .OSD_WE(osd_we), .OSD_ROW(row), .OSD_COL(col), .OSD_CODE(code)
  );
  cch_host_model host (.clk(ref_clk), .sda(sda_w), .scl(h_scl), .sda_oe(h_oe), .nack(h_nack),
    .rd_seen(rd_seen), .rd_byte(rd_byte));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic wb(input logic [7:0] d);
    host.wbyte(d);
    chk({15'h0000, h_nack}, 16'h0000);
  endtask : wb

  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    host.start();
    wb({`CCH_I2C_ADDR, 1'b0});
    wb(sub);
    foreach (d[i]) wb(d[i]);
    host.stop();
  endtask : wr

  task automatic rd(input logic [7:0] sub, input int n);
    host.start();
    wb({`CCH_I2C_ADDR, 1'b0});
    wb(sub);
    host.start();
    wb({`CCH_I2C_ADDR, 1'b1});
    for (int i = 1; i <= n; i++) host.rbyte(i == n);
    host.stop();
  endtask : rd

  task automatic acq(input logic e, input logic f, input logic h);
    t = xs();
    x = t[7:0];
    y = t[15:8];
    @(posedge acq_clk);
    b1 <= x;
    b2 <= y;
    ext_svc <= e;
    fld <= f;
    halt <= h;
    acq_valid <= 1'b1;
    @(posedge acq_clk);
    acq_valid <= 1'b0;
  endtask : acq

  task automatic wait_rdy();
    for (int i = 0; i < 40 && rdy_oe !== 1'b1; i++) @(posedge ref_clk);
    chk({15'h0000, rdy_oe}, 16'h0001);
  endtask : wait_rdy

  // results are matched oldest first against the notes left by the driver
  always @(posedge ref_clk) begin
    if (rd_seen === 1'b1) chk({8'h00, rd_byte}, {8'h00, exp_rd.pop_front()});
    if (osd_we === 1'b1) chk({row, col, code}, exp_osd.pop_front());
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    acq_rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({c0, c1}, 16'h0000);
    // a foreign address must be left unanswered
    host.start();
    host.wbyte({`CCH_I2C_ADDR ^ 7'h01, 1'b0});
    chk({15'h0000, h_nack}, 16'h0001);
    host.stop();
    exp_rd = '{8'h80, 8'h00, 8'h00, 8'h00};
    rd(8'h80, 4);
    exp_rd.push_back(8'h00);
    rd(8'h80, 1);
    t = xs();
    wr(8'h00, '{t[7:0], 8'h02});
    chk({c0, c1}, {t[7:0], 8'h02});
    for (int m = 0; m < 4; m++) begin
      v = m[1:0];
      wr(8'h01, '{{1'b0, v[0], 2'b00, ~v, v}});
      chk({14'h0000, disp}, {14'h0000, v});
      chk({14'h0000, sty}, {14'h0000, ~v});
      chk({15'h0000, chan}, {15'h0000, v[0]});
    end
    t = xs();
    exp_osd.push_back({4'h5, 5'h1e, t[6:0]});
    exp_osd.push_back({4'h5, 5'h1f, t[14:8]});
    exp_osd.push_back({4'h6, 5'h00, t[22:16]});
    wr(8'h02, '{8'h05, 8'h1e, t[7:0], t[15:8], t[23:16]});
    acq(1'b1, 1'b1, 1'b0);
    wait_rdy();
    exp_rd = '{8'h0d, x, y};
    rd(8'h80, 3);
    chk({15'h0000, rdy_oe}, 16'h0000);
    acq(1'b0, 1'b0, 1'b1);
    wait_rdy();
    exp_rd.push_back(y);
    rd(8'h82, 1);
    chk({15'h0000, rdy_oe}, 16'h0000);
    exp_rd.push_back(8'h02);
    rd(8'h80, 1);
    halt <= 1'b0;
    sel <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      {pin_rdy, pin_scl, pin_sda} <= p[2:0];
      repeat (6) @(posedge ref_clk);
      v = p[1:0];
      chk({14'h0000, disp}, {14'h0000, v});
      chk({15'h0000, chan}, {15'h0000, p[2]});
      chk({13'h0000, black, sty}, (v == 2'b10) ? 16'h0006 : 16'h0000);
      chk({15'h0000, rdy_oe}, 16'h0000);
    end
    wrap_up();
  end
endmodule : tb_top
